//--- common/ahg_pkg.sv
// Summary of operation
// - Active gear link makes demand position follow driving axis motion times ratio, only while no origin search runs.
// - Gear ratio is signed, base edges per driving edge, sixteen fraction bits.
// - New link command with same driving axis updates ratio without a break.
// - Link command naming another driving axis while linked is ignored.
// - Move-cancel or emergency halt ends an active gear link.
// - Window end position holds where the registration window ends.
// - Slow search speed sets slow phase speed; any non-negative value.
// - Servo adds derivative term, change in following error times gain; gain resets zero.
// - Open loop drives the open-loop value, bounded by the output clamp limit.
// - Drive source is open-loop value or servo result; applied value readable.
// - Applied-output readback spans -2048 to 2047 for minus to plus 10 V.
// - Sequence zero copies measured into demand for all axes, clears error flag unless the following error is over its limit in that cycle.
// - A sequence moves forward at slow speed until the Z marker.
// - A sequence moves reverse at slow speed until the Z marker.
// - Forward fast to switch set, then reverse slow until switch released.
// - Reverse fast to switch set, then forward slow until switch released.
// - Forward fast to switch set, then reverse slow until Z marker.
// - Reverse fast to switch set, then forward slow until Z marker.
// - Moving search end zeroes demand, shifts measured to keep following error.
// - Fast phase uses fast speed, slow phase uses slow speed.
// - Datum switch is the selected input, set when that input is low.
// - Feed-hold, jog and limit inputs are active low.
// - Switch select accepts 0 to 15 and 20 to 31; -1 means none.
package ahg_pkg;
  localparam int POS_W = 32;
  localparam int DELTA_W = 16;
  localparam int NUM_AXES = 4;
  localparam int AXIS_SEL_W = 2;
  localparam int RATIO_W = 32;
  localparam int RATIO_FRAC = 16;
  localparam int ACC_W = DELTA_W + RATIO_W;
  localparam int SPEED_W = 16;
  localparam int GAIN_W = 16;
  localparam int DAC_W = 12;
  localparam int CLAMP_W = 11;
  localparam int IO_W = 32;
  localparam int SEL_W = 6;
  localparam int SEQ_W = 3;
  localparam int STAT_W = 8;
  localparam logic signed [DAC_W-1:0] DAC_MIN = 12'sh800;
  localparam logic signed [DAC_W-1:0] DAC_MAX = 12'sh7FF;
  localparam logic [SEQ_W-1:0] SEQ_COPY = 3'h0;
  localparam logic [SEQ_W-1:0] SEQ_Z_FWD = 3'h1;
  localparam logic [SEQ_W-1:0] SEQ_Z_REV = 3'h2;
  localparam logic [SEQ_W-1:0] SEQ_SW_FWD = 3'h3;
  localparam logic [SEQ_W-1:0] SEQ_SW_REV = 3'h4;
  localparam logic [SEQ_W-1:0] SEQ_SWZ_FWD = 3'h5;
  localparam logic [SEQ_W-1:0] SEQ_SWZ_REV = 3'h6;
  localparam logic signed [SEL_W-1:0] SEL_NONE = 6'sh3F;
  localparam logic signed [SEL_W-1:0] SEL_LO_MAX = 6'sh0F;
  localparam logic signed [SEL_W-1:0] SEL_HI_MIN = 6'sh14;
  localparam logic signed [SEL_W-1:0] SEL_HI_MAX = 6'sh1F;
  localparam int ST_FE = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_GEAR = 2;
  localparam int ST_LIM_FWD = 3;
  localparam int ST_LIM_REV = 4;
  localparam int ST_HOLD = 5;
  localparam int ST_JOG_FWD = 6;
  localparam int ST_JOG_REV = 7;
  // Synchronised pin vector layout
  localparam int PIN_HOLD = 0;
  localparam int PIN_JOG_FWD = 1;
  localparam int PIN_JOG_REV = 2;
  localparam int PIN_LIM_FWD = 3;
  localparam int PIN_LIM_REV = 4;
  localparam int PIN_Z = 5;
  localparam int PIN_IO = 6;
  localparam int PIN_W = PIN_IO + IO_W;
  typedef enum logic [1:0] {AHG_IDLE, AHG_FAST, AHG_SLOW, AHG_END} ahg_state_t;
endpackage : ahg_pkg

//--- hdl/ahg_axis.sv
`timescale 1ns/10ps
module ahg_axis (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_servo_tick,
  input wire logic signed [ahg_pkg::POS_W-1:0] i_encoder_pos,
  input wire logic [ahg_pkg::NUM_AXES*ahg_pkg::DELTA_W-1:0] i_axis_delta,
  input wire logic i_link_req,
  input wire logic signed [ahg_pkg::RATIO_W-1:0] i_link_ratio,
  input wire logic [ahg_pkg::AXIS_SEL_W-1:0] i_link_axis,
  input wire logic i_move_cancel,
  input wire logic i_emergency_halt,
  input wire logic i_datum_req,
  input wire logic [ahg_pkg::SEQ_W-1:0] i_datum_seq,
  input wire logic i_datum_all,
  input wire logic [ahg_pkg::SPEED_W-1:0] i_fast_speed,
  input wire logic [ahg_pkg::SPEED_W-1:0] i_slow_speed,
  input wire logic signed [ahg_pkg::SEL_W-1:0] i_origin_switch_select,
  input wire logic [ahg_pkg::IO_W-1:0] i_io_pins,
  input wire logic i_z_marker,
  input wire logic i_feedhold_n,
  input wire logic i_jog_fwd_n,
  input wire logic i_jog_rev_n,
  input wire logic i_limit_fwd_n,
  input wire logic i_limit_rev_n,
  input wire logic i_closed_loop,
  input wire logic signed [ahg_pkg::DAC_W-1:0] i_open_loop_value,
  input wire logic [ahg_pkg::CLAMP_W-1:0] i_output_clamp_limit,
  input wire logic signed [ahg_pkg::GAIN_W-1:0] i_p_gain,
  input wire logic i_d_gain_wr,
  input wire logic signed [ahg_pkg::GAIN_W-1:0] i_d_gain,
  input wire logic [ahg_pkg::POS_W-1:0] i_fe_limit,
  input wire logic i_window_end_wr,
  input wire logic signed [ahg_pkg::POS_W-1:0] i_window_end_value,
  output logic o_datum_all,
  output logic signed [ahg_pkg::POS_W-1:0] o_demand_pos,
  output logic signed [ahg_pkg::POS_W-1:0] o_measured_pos,
  output logic signed [ahg_pkg::DAC_W-1:0] o_drive_value,
  output logic signed [ahg_pkg::POS_W-1:0] o_window_end_position,
  output logic [ahg_pkg::STAT_W-1:0] o_axis_status_word
);
  logic [ahg_pkg::PIN_W-1:0] pins;
  logic hold_act, lim_fwd_act, lim_rev_act, sw_valid, sw_set, z_hit;
  logic gear_active, gear_vld, stop;
  logic signed [ahg_pkg::POS_W-1:0] gear_step, meas, fe, fe_diff;
  logic signed [ahg_pkg::POS_W-1:0] speed, servo_raw;
  logic signed [ahg_pkg::DAC_W-1:0] lim_hi, lim_lo, src;
  ahg_pkg::ahg_state_t state_ff, nxt_state;
  logic [ahg_pkg::SEQ_W-1:0] seq_ff, nxt_seq;
  logic fwd_ff, nxt_fwd;
  logic z_prev_ff, nxt_z_prev;
  logic signed [ahg_pkg::POS_W-1:0] dpos_ff, nxt_dpos;
  logic signed [ahg_pkg::POS_W-1:0] off_ff, nxt_off;
  logic signed [ahg_pkg::POS_W-1:0] fe_prev_ff, nxt_fe_prev;
  logic signed [ahg_pkg::GAIN_W-1:0] d_gain_ff, nxt_d_gain;
  logic signed [ahg_pkg::DAC_W-1:0] drive_ff, nxt_drive;
  logic signed [ahg_pkg::POS_W-1:0] win_ff, nxt_win;
  logic fe_flag_ff, nxt_fe_flag;
  logic datum_all_ff, nxt_datum_all;

  // Pin inputs pass two flip-flops first
  ahg_pin_sync #(.W(ahg_pkg::PIN_W)) u_sync (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_pins({i_io_pins, i_z_marker, i_limit_rev_n, i_limit_fwd_n,
             i_jog_rev_n, i_jog_fwd_n, i_feedhold_n}),
    .o_pins(pins)
  );

  assign stop = i_move_cancel | i_emergency_halt;

  // Electronic gearbox
  ahg_gearbox u_gear (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_servo_tick(i_servo_tick),
    .i_link_req(i_link_req),
    .i_link_ratio(i_link_ratio),
    .i_link_axis(i_link_axis),
    .i_stop(stop),
    .i_axis_delta(i_axis_delta),
    .o_active(gear_active),
    .o_step_valid(gear_vld),
    .o_step(gear_step)
  );

  // Low-true pin decode and datum switch selection
  always_comb begin
    hold_act = !pins[ahg_pkg::PIN_HOLD];
    lim_fwd_act = !pins[ahg_pkg::PIN_LIM_FWD];
    lim_rev_act = !pins[ahg_pkg::PIN_LIM_REV];
    sw_valid = (i_origin_switch_select >= 6'sh00
                && i_origin_switch_select <= ahg_pkg::SEL_LO_MAX)
               || (i_origin_switch_select >= ahg_pkg::SEL_HI_MIN
                && i_origin_switch_select <= ahg_pkg::SEL_HI_MAX);
    sw_set = sw_valid && !pins[ahg_pkg::PIN_IO
             + int'(i_origin_switch_select[4:0])];
    z_hit = pins[ahg_pkg::PIN_Z] && !z_prev_ff;
    meas = i_encoder_pos + off_ff;
    fe = dpos_ff - meas;
    fe_diff = fe - fe_prev_ff;
  end

  // Origin search sequencer and demand position
  always_comb begin
    nxt_state = state_ff;
    nxt_seq = seq_ff;
    nxt_fwd = fwd_ff;
    nxt_dpos = dpos_ff;
    nxt_off = off_ff;
    nxt_fe_flag = fe_flag_ff;
    nxt_datum_all = 1'b0;
    nxt_z_prev = pins[ahg_pkg::PIN_Z];
    speed = (state_ff == ahg_pkg::AHG_FAST)
          ? $signed({16'h0000, i_fast_speed})
          : $signed({16'h0000, i_slow_speed});
    if (gear_vld && state_ff == ahg_pkg::AHG_IDLE) begin
      nxt_dpos = dpos_ff + gear_step;
    end
    case (state_ff)
      ahg_pkg::AHG_IDLE: begin
        if (i_datum_req && !stop) begin
          nxt_seq = i_datum_seq;
          case (i_datum_seq)
            ahg_pkg::SEQ_COPY: nxt_datum_all = 1'b1;
            ahg_pkg::SEQ_Z_FWD, ahg_pkg::SEQ_Z_REV: begin
              nxt_state = ahg_pkg::AHG_SLOW;
              nxt_fwd = (i_datum_seq == ahg_pkg::SEQ_Z_FWD);
            end
            ahg_pkg::SEQ_SW_FWD, ahg_pkg::SEQ_SWZ_FWD: begin
              if (sw_valid) begin
                nxt_state = ahg_pkg::AHG_FAST;
                nxt_fwd = 1'b1;
              end
            end
            ahg_pkg::SEQ_SW_REV, ahg_pkg::SEQ_SWZ_REV: begin
              if (sw_valid) begin
                nxt_state = ahg_pkg::AHG_FAST;
                nxt_fwd = 1'b0;
              end
            end
            default: nxt_state = ahg_pkg::AHG_IDLE;
          endcase
        end
      end
      ahg_pkg::AHG_FAST: begin
        if (sw_set) begin
          nxt_state = ahg_pkg::AHG_SLOW;
          nxt_fwd = !fwd_ff;
        end
      end
      ahg_pkg::AHG_SLOW: begin
        if (seq_ff == ahg_pkg::SEQ_SW_FWD || seq_ff == ahg_pkg::SEQ_SW_REV) begin
          if (!sw_set) begin
            nxt_state = ahg_pkg::AHG_END;
          end
        end else if (z_hit) begin
          nxt_state = ahg_pkg::AHG_END;
        end
      end
      ahg_pkg::AHG_END: begin
        nxt_dpos = '0;
        nxt_off = off_ff - dpos_ff;
        nxt_state = ahg_pkg::AHG_IDLE;
      end
      default: nxt_state = ahg_pkg::AHG_IDLE;
    endcase
    // Searching axis steps each tick unless held
    if ((state_ff == ahg_pkg::AHG_FAST || state_ff == ahg_pkg::AHG_SLOW)
        && i_servo_tick && !hold_act) begin
      nxt_dpos = fwd_ff ? dpos_ff + speed : dpos_ff - speed;
    end
    // Cancel, halt or a limit in the moving direction aborts a search
    if (state_ff != ahg_pkg::AHG_IDLE && state_ff != ahg_pkg::AHG_END
        && (stop || (fwd_ff ? lim_fwd_act : lim_rev_act))) begin
      nxt_state = ahg_pkg::AHG_IDLE;
    end
    if (datum_all_ff || i_datum_all) begin
      nxt_dpos = meas;
      nxt_fe_flag = 1'b0;
    end
    // Error set wins over the clear above
    if ((fe < 0 ? -fe : fe) > $signed(i_fe_limit)) begin
      nxt_fe_flag = 1'b1;
    end
  end

  // Servo loop, drive source and clamp
  always_comb begin
    nxt_fe_prev = fe_prev_ff;
    nxt_d_gain = i_d_gain_wr ? i_d_gain : d_gain_ff;
    nxt_win = i_window_end_wr ? i_window_end_value : win_ff;
    nxt_drive = drive_ff;
    lim_hi = $signed({1'b0, i_output_clamp_limit});
    lim_lo = -lim_hi - 12'sh001;
    servo_raw = ahg_pkg::POS_W'(i_p_gain * fe)
              + ahg_pkg::POS_W'(d_gain_ff * fe_diff);
    if (i_closed_loop) begin
      if (servo_raw > ahg_pkg::POS_W'(lim_hi)) begin
        src = lim_hi;
      end else if (servo_raw < ahg_pkg::POS_W'(lim_lo)) begin
        src = lim_lo;
      end else begin
        src = servo_raw[ahg_pkg::DAC_W-1:0];
      end
    end else if (i_open_loop_value > lim_hi) begin
      src = lim_hi;
    end else if (i_open_loop_value < lim_lo) begin
      src = lim_lo;
    end else begin
      src = i_open_loop_value;
    end
    if (i_servo_tick) begin
      nxt_fe_prev = fe;
      nxt_drive = src;
    end
  end

  // State registers
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_ff <= ahg_pkg::AHG_IDLE;
      seq_ff <= ahg_pkg::SEQ_COPY;
      fwd_ff <= 1'b0;
      z_prev_ff <= 1'b1;
      dpos_ff <= '0;
      off_ff <= '0;
      fe_prev_ff <= '0;
      d_gain_ff <= '0;
      drive_ff <= '0;
      win_ff <= '0;
      fe_flag_ff <= 1'b0;
      datum_all_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      seq_ff <= nxt_seq;
      fwd_ff <= nxt_fwd;
      z_prev_ff <= nxt_z_prev;
      dpos_ff <= nxt_dpos;
      off_ff <= nxt_off;
      fe_prev_ff <= nxt_fe_prev;
      d_gain_ff <= nxt_d_gain;
      drive_ff <= nxt_drive;
      win_ff <= nxt_win;
      fe_flag_ff <= nxt_fe_flag;
      datum_all_ff <= nxt_datum_all;
    end
  end

  // Outputs and status word
  assign o_datum_all = datum_all_ff;
  assign o_demand_pos = dpos_ff;
  assign o_measured_pos = meas;
  assign o_drive_value = drive_ff;
  assign o_window_end_position = win_ff;
  always_comb begin
    o_axis_status_word = '0;
    o_axis_status_word[ahg_pkg::ST_FE] = fe_flag_ff;
    o_axis_status_word[ahg_pkg::ST_BUSY] = state_ff != ahg_pkg::AHG_IDLE;
    o_axis_status_word[ahg_pkg::ST_GEAR] = gear_active;
    o_axis_status_word[ahg_pkg::ST_LIM_FWD] = lim_fwd_act;
    o_axis_status_word[ahg_pkg::ST_LIM_REV] = lim_rev_act;
    o_axis_status_word[ahg_pkg::ST_HOLD] = hold_act;
    o_axis_status_word[ahg_pkg::ST_JOG_FWD] = !pins[ahg_pkg::PIN_JOG_FWD];
    o_axis_status_word[ahg_pkg::ST_JOG_REV] = !pins[ahg_pkg::PIN_JOG_REV];
  end

  a_search_end_zero: assert property (@(posedge i_clock) disable iff (!i_rstn)
    state_ff == ahg_pkg::AHG_END && !datum_all_ff && !i_datum_all
    |=> dpos_ff == 0 && off_ff == $past(off_ff) - $past(dpos_ff))
    else $error("search end did not zero demand");
  a_datum0_copy: assert property (@(posedge i_clock) disable iff (!i_rstn)
    i_datum_all |=> dpos_ff == $past(meas))
    else $error("sequence zero did not copy position");
  a_slow_step: assert property (@(posedge i_clock) disable iff (!i_rstn)
    state_ff == ahg_pkg::AHG_SLOW && i_servo_tick && !hold_act && fwd_ff
    && !i_datum_all && !datum_all_ff
    |=> dpos_ff == $past(dpos_ff) + $signed({16'h0000, $past(i_slow_speed)}))
    else $error("slow phase speed wrong");
  a_drive_range: assert property (@(posedge i_clock) disable iff (!i_rstn)
    i_servo_tick ##1 $stable(i_output_clamp_limit)
    |-> drive_ff <= $signed({1'b0, i_output_clamp_limit})
    && drive_ff >= -$signed({1'b0, i_output_clamp_limit}) - 12'sh001)
    else $error("drive beyond clamp");
  a_open_loop_src: assert property (@(posedge i_clock) disable iff (!i_rstn)
    i_servo_tick && !i_closed_loop && i_output_clamp_limit == 11'h7FF
    |=> drive_ff == $past(i_open_loop_value))
    else $error("open loop value not applied");
  a_dgain_hold: assert property (@(posedge i_clock) disable iff (!i_rstn)
    !i_d_gain_wr |=> $stable(d_gain_ff))
    else $error("derivative gain changed");
  a_switch_low: assert property (@(posedge i_clock) disable iff (!i_rstn)
    state_ff == ahg_pkg::AHG_FAST && !sw_valid ##0 1'b1 |-> !sw_set)
    else $error("switch seen without valid select");
endmodule : ahg_axis

//--- hdl/ahg_gearbox.sv
`timescale 1ns/10ps
module ahg_gearbox (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_servo_tick,
  input wire logic i_link_req,
  input wire logic signed [ahg_pkg::RATIO_W-1:0] i_link_ratio,
  input wire logic [ahg_pkg::AXIS_SEL_W-1:0] i_link_axis,
  input wire logic i_stop,
  input wire logic [ahg_pkg::NUM_AXES*ahg_pkg::DELTA_W-1:0] i_axis_delta,
  output logic o_active,
  output logic o_step_valid,
  output logic signed [ahg_pkg::POS_W-1:0] o_step
);
  logic active_ff, nxt_active;
  logic [ahg_pkg::AXIS_SEL_W-1:0] drv_ff, nxt_drv;
  logic signed [ahg_pkg::RATIO_W-1:0] ratio_ff, nxt_ratio;
  logic [ahg_pkg::RATIO_FRAC-1:0] frac_ff, nxt_frac;
  logic signed [ahg_pkg::POS_W-1:0] step_ff, nxt_step;
  logic step_vld_ff, nxt_step_vld;
  logic signed [ahg_pkg::DELTA_W-1:0] delta;
  logic signed [ahg_pkg::ACC_W-1:0] sum;

  // Link control, ratio scaling and fraction carry
  always_comb begin
    nxt_active = active_ff;
    nxt_drv = drv_ff;
    nxt_ratio = ratio_ff;
    nxt_frac = frac_ff;
    nxt_step = step_ff;
    nxt_step_vld = 1'b0;
    delta = i_axis_delta[drv_ff*ahg_pkg::DELTA_W +: ahg_pkg::DELTA_W];
    sum = ahg_pkg::ACC_W'(delta * ratio_ff)
        + $signed({{(ahg_pkg::ACC_W-ahg_pkg::RATIO_FRAC){1'b0}}, frac_ff});
    if (active_ff && i_servo_tick) begin
      nxt_step = sum[ahg_pkg::POS_W+ahg_pkg::RATIO_FRAC-1:ahg_pkg::RATIO_FRAC];
      nxt_frac = sum[ahg_pkg::RATIO_FRAC-1:0];
      nxt_step_vld = 1'b1;
    end
    if (i_stop) begin
      nxt_active = 1'b0;
      nxt_frac = '0;
    end else if (i_link_req) begin
      if (!active_ff) begin
        nxt_active = 1'b1;
        nxt_drv = i_link_axis;
        nxt_ratio = i_link_ratio;
        nxt_frac = '0;
      end else if (i_link_axis == drv_ff) begin
        nxt_ratio = i_link_ratio;
      end
      // Other driving axis while linked: ignored
    end
  end

  // Link state registers
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      active_ff <= 1'b0;
      drv_ff <= '0;
      ratio_ff <= '0;
      frac_ff <= '0;
      step_ff <= '0;
      step_vld_ff <= 1'b0;
    end else begin
      active_ff <= nxt_active;
      drv_ff <= nxt_drv;
      ratio_ff <= nxt_ratio;
      frac_ff <= nxt_frac;
      step_ff <= nxt_step;
      step_vld_ff <= nxt_step_vld;
    end
  end

  assign o_active = active_ff;
  assign o_step_valid = step_vld_ff;
  assign o_step = step_ff;

  a_gear_stop_ends: assert property (@(posedge i_clock) disable iff (!i_rstn)
    i_stop |=> !o_active) else $error("gear link survived a stop");
  a_gear_other_axis: assert property (@(posedge i_clock) disable iff (!i_rstn)
    active_ff && i_link_req && !i_stop && i_link_axis != drv_ff
    |=> $stable(drv_ff) && $stable(ratio_ff) && active_ff)
    else $error("link with other driving axis not ignored");
  a_gear_ratio_upd: assert property (@(posedge i_clock) disable iff (!i_rstn)
    active_ff && i_link_req && !i_stop && i_link_axis == drv_ff
    |=> active_ff && ratio_ff == $past(i_link_ratio))
    else $error("ratio not updated on live link");
endmodule : ahg_gearbox

//--- hdl/ahg_pin_sync.sv
`timescale 1ns/10ps
module ahg_pin_sync #(
  parameter int W = 1
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_pins,
  output logic [W-1:0] o_pins
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // Two-stage synchroniser, idles high (inactive for low-true pins)
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_ff <= '1;
      sync_ff <= '1;
    end else begin
      meta_ff <= i_pins;
      sync_ff <= meta_ff;
    end
  end

  assign o_pins = sync_ff;
endmodule : ahg_pin_sync

//--- tb/ahg_drive_model.sv
`timescale 1ns/10ps
module ahg_drive_model #(
  parameter int SW_POS = 200,
  parameter int SW_PIN = 5
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_servo_tick,
  input wire logic signed [31:0] i_demand_pos,
  output logic signed [31:0] o_encoder_pos,
  output logic o_z_marker,
  output logic [31:0] o_io_pins
);
  // Encoder trails demand by one servo tick, like a lagging drive
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_encoder_pos <= '0;
    end else if (i_servo_tick) begin
      o_encoder_pos <= i_demand_pos;
    end
  end
  // Z window every 128 edges; datum switch closed beyond +-SW_POS
  always_comb begin
    o_z_marker = (o_encoder_pos[6:4] == 3'h0);
    o_io_pins = 32'hFFFF_FFFF;
    o_io_pins[SW_PIN] = !(o_encoder_pos >= SW_POS || o_encoder_pos <= -SW_POS);
  end
endmodule : ahg_drive_model

//--- tb/tb.sv
`timescale 1ns/10ps
module tb;
  logic i_clock = 1'b0, i_rstn = 1'b0, tick = 1'b0, lreq = 1'b0;
  logic cancel = 1'b0, halt = 1'b0, dreq = 1'b0, dall = 1'b0, cl = 1'b0;
  logic dgwr = 1'b0, wwr = 1'b0, oall, z;
  logic [4:0] pn = 5'h1F;
  logic [2:0] seq = 3'h0;
  logic [1:0] lax = 2'h1;
  logic [63:0] dlt = 64'h0000_0005_0008_0000;
  logic signed [31:0] ratio = 32'sh4000, wval = '0, enc, dem, mpos, wend;
  logic signed [31:0] a, dl, off = '0;
  logic [31:0] fel = 32'hFFFF, io;
  logic [15:0] fsp = 16'h14, ssp = 16'h3;
  logic signed [15:0] pg = '0, dg = '0;
  logic signed [5:0] sel = 6'sh05;
  logic signed [11:0] olv = '0, drv;
  logic [10:0] lim = 11'h7FF;
  logic [7:0] st;
  int n_mismatch = 0, checks = 0, cyc = 0, tc = 0;
  ahg_axis dut (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_servo_tick(tick),
    .i_encoder_pos(enc), .i_axis_delta(dlt), .i_link_req(lreq),
    .i_link_ratio(ratio), .i_link_axis(lax), .i_move_cancel(cancel),
    .i_emergency_halt(halt), .i_datum_req(dreq), .i_datum_seq(seq),
    .i_datum_all(dall), .i_fast_speed(fsp), .i_slow_speed(ssp),
    .i_origin_switch_select(sel), .i_io_pins(io), .i_z_marker(z),
    .i_feedhold_n(pn[2]), .i_jog_fwd_n(pn[3]), .i_jog_rev_n(pn[4]),
    .i_limit_fwd_n(pn[0]), .i_limit_rev_n(pn[1]), .i_closed_loop(cl),
    .i_open_loop_value(olv), .i_output_clamp_limit(lim), .i_p_gain(pg),
    .i_d_gain_wr(dgwr), .i_d_gain(dg), .i_fe_limit(fel),
    .i_window_end_wr(wwr), .i_window_end_value(wval), .o_datum_all(oall),
    .o_demand_pos(dem), .o_measured_pos(mpos), .o_drive_value(drv),
    .o_window_end_position(wend), .o_axis_status_word(st)
  );
  ahg_drive_model drv_model (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_servo_tick(tick),
    .i_demand_pos(dem), .o_encoder_pos(enc), .o_z_marker(z), .o_io_pins(io)
  );
  // Clock
  initial forever #20 i_clock = ~i_clock;
  // Servo tick every 8 cycles, and the hang guard
  always @(posedge i_clock) begin
    tc <= (tc == 7) ? 0 : tc + 1;
    tick <= (tc == 7);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic cyc_n(int n);
    repeat (n) @(posedge i_clock);
  endtask : cyc_n
  task automatic wtick();
    @(posedge i_clock iff tick);
  endtask : wtick
  // Gear link command with ratio and driving axis
  task automatic link(logic signed [31:0] r, logic [1:0] ax);
    @(posedge i_clock);
    ratio <= r;
    lax <= ax;
    lreq <= 1'b1;
    @(posedge i_clock);
    lreq <= 1'b0;
  endtask : link
  task automatic dat(logic [2:0] s);
    @(posedge i_clock);
    seq <= s;
    dreq <= 1'b1;
    @(posedge i_clock);
    dreq <= 1'b0;
  endtask : dat
  // Demand change over one servo tick
  task automatic stepc(logic [31:0] e);
    wtick();
    cyc_n(4);
    a = dem;
    wtick();
    cyc_n(4);
    chk("step", e, dem - a);
  endtask : stepc
  function automatic logic signed [31:0] clampv(logic signed [31:0] v, int l);
    if (v > l) return l;
    if (v < -l - 1) return -l - 1;
    return v;
  endfunction : clampv
  logic signed [11:0] ov[4] = '{12'sh400, 12'sh800, 12'sh7FF, 12'sh800};
  logic [10:0] lv[4] = '{11'h7FF, 11'h7FF, 11'h064, 11'h064};
  // Main sequence
  initial begin
    cyc_n(5);
    i_rstn <= 1'b1;
    cyc_n(2);
    chk("drive", 0, drv);
    chk("status", 0, st);
    @(posedge i_clock);
    wval <= 32'sh1234_5678;
    wwr <= 1'b1;
    @(posedge i_clock);
    wwr <= 1'b0;
    cyc_n(2);
    chk("window", 32'h1234_5678, wend);
    for (int i = 0; i < 4; i++) begin
      @(posedge i_clock);
      olv <= ov[i];
      lim <= lv[i];
      wtick();
      cyc_n(2);
      chk("open", clampv(ov[i], lv[i]), drv);
    end
    for (int i = 0; i < 5; i++) begin
      @(posedge i_clock);
      pn <= ~(5'h1 << i);
      cyc_n(4);
      chk("pin", 8'h8 << i, st & 8'hF8);
    end
    @(posedge i_clock);
    pn <= 5'h1F;
    lim <= 11'h7FF;
    link(32'sh4000, 2'h1);
    cyc_n(2);
    chk("gear", 8'h4, st & 8'h4);
    stepc(32'h2);
    link(32'sh2_0000, 2'h1);
    stepc(32'h10);
    link(32'sh1_0000, 2'h2);
    stepc(32'h10);
    link(32'shFFFF_8000, 2'h1);
    fel <= '0;
    stepc(32'hFFFF_FFFC);
    chk("fe", 8'h1, st & 8'h1);
    @(posedge i_clock);
    cancel <= 1'b1;
    @(posedge i_clock);
    cancel <= 1'b0;
    stepc(32'h0);
    link(32'sh4000, 2'h1);
    @(posedge i_clock);
    halt <= 1'b1;
    fel <= 32'hFFFF;
    @(posedge i_clock);
    halt <= 1'b0;
    stepc(32'h0);
    chk("gear", 0, st & 8'h4);
    cyc_n(20);
    dat(3'h0);
    #1;
    chk("all", 1, oall);
    dall <= 1'b1;
    @(posedge i_clock);
    dall <= 1'b0;
    cyc_n(3);
    chk("copy", enc, dem);
    chk("fe", 0, st & 8'h1);
    sel <= 6'sh10;
    dat(3'h3);
    cyc_n(3);
    chk("busy", 0, st & 8'h2);
    sel <= 6'sh3F;
    dat(3'h4);
    cyc_n(3);
    chk("busy", 0, st & 8'h2);
    sel <= 6'sh05;
    for (int s = 1; s < 7; s++) begin
      a = dem;
      dat(3'(s));
      for (int k = 0; k < 200 && dem === a; k++) @(posedge i_clock);
      chk("first", (s > 2 ? fsp : ssp) * (s % 2 ? 1 : -1), dem - a);
      dl = dem;
      for (int k = 0; k < 4000 && st[1] !== 1'b0; k++) begin
        @(posedge i_clock);
        if (dem !== 0) dl = dem;
      end
      cyc_n(2);
      off = off - dl;
      chk("zero", 0, dem);
      chk("meas", enc + off, mpos);
    end
    @(posedge i_clock);
    cl <= 1'b1;
    pg <= 16'sh1;
    wtick();
    wtick();
    cyc_n(2);
    chk("servo", clampv(-off, 2047), drv);
    end_of_test();
  end
endmodule : tb
